//--- rtl/i2c_cond_defs.svh
`ifndef I2C_COND_DEFS_SVH
`define I2C_COND_DEFS_SVH

// ==========================================
// clock and timing
`define CLK_PERIOD_NS 20
`define HOLD_STD_NS 100
`define HOLD_LONG_NS 300
// least times round up to whole clock cycles
`define HOLD_STD_CYC ((`HOLD_STD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_LONG_CYC ((`HOLD_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCL_HALF_NS 5000
`define SCL_HALF_CYC ((`SCL_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================
// byte framing
`define BITS_PER_BYTE 8
`define ACK_SLOT 8
`define RW_BIT_POS 0
`define FIFO_DEPTH_DEF 8

// ==========================================
// reset values and hold counter width
`define SYNC_RST 2'h3
`define HOLD_CNT_W 4

`endif

//--- rtl/i2c_cond_pkg.sv
package i2c_cond_pkg;

    // ==========================================
    // bus condition pulses, one cycle each
    typedef struct packed {
        logic start;
        logic restart;
        logic stop;
    } bus_ev_t;

    // ==========================================
    // received byte as it enters the fifo
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } rx_word_t;

    // ==========================================
    // host sequencer states
    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_LOW,
        H_HIGH,
        H_STOP_LOW,
        H_STOP_HIGH,
        H_LOST
    } host_state_t;

endpackage

//--- rtl/rx_fifo.sv
module rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;

    // ==========================================
    // handshake decode
    wire push = in_valid & in_ready;
    wire pop_mem = (count != '0) & (~out_valid | out_ready);
    assign in_ready = (count != CW'(DEPTH));

    // storage array, no reset needed
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce) begin
            if (push) wr_ptr <= wr_ptr + AW'(1);
            if (pop_mem) rd_ptr <= rd_ptr + AW'(1);
            count <= count + CW'(push) - CW'(pop_mem);
        end
    end

    // registered read stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            if (pop_mem) begin
                out_valid <= 1'b1;
                out_data <= mem[rd_ptr];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

//--- rtl/i2c_bus_engine.sv
`include "i2c_cond_defs.svh"

module i2c_bus_engine #(
    parameter int HALF_CYC = `SCL_HALF_CYC,
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sda_hold_long_sel,
    input wire logic clock_release_ctl,
    input wire logic start_irq_en,
    input wire logic stop_irq_en,
    input wire logic mode_cond_irq,
    input wire logic client_en,
    input wire logic addr_hold_en,
    input wire logic data_hold_en,
    input wire logic ack_value_sel,
    input wire logic buffer_full_flag,
    input wire logic rx_overflow_flag,
    input wire logic host_start_req,
    input wire logic [7:0] host_tx_data,
    output logic host_busy,
    output logic arb_lost,
    output logic bus_collision,
    output logic ack_result_flag,
    output logic ack_window_flag,
    output logic bus_busy,
    output i2c_cond_pkg::bus_ev_t bus_event,
    output logic cond_irq,
    output logic read_req,
    output logic rx_valid,
    input wire logic rx_ready,
    output i2c_cond_pkg::rx_word_t rx_data
);
    localparam int HW = $clog2(HALF_CYC + 1);

    // ==========================================
    // pin synchronisers and edge detection
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;

    // two flops per pin, then one more for edges
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_sync <= `SYNC_RST;
            sda_sync <= `SYNC_RST;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce) begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;

    // ==========================================
    // start, stop and restart detection
    logic low_seen;
    logic rel_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s & low_seen;
    wire restart_det = start_det & bus_busy & low_seen;
    wire release_rise = clock_release_ctl & ~rel_d;

    // bus state follows detected conditions
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_busy <= 1'b0;
            low_seen <= 1'b0;
            rel_d <= 1'b0;
            bus_event <= '0;
            cond_irq <= 1'b0;
        end else if (ce) begin
            rel_d <= clock_release_ctl;
            if (start_det) bus_busy <= 1'b1;
            else if (stop_det) bus_busy <= 1'b0;
            if (start_det || stop_det) low_seen <= 1'b0;
            else if (bus_busy && !scl_s) low_seen <= 1'b1;
            bus_event <= '{start: start_det & ~restart_det, restart: restart_det,
                           stop: stop_det};
            cond_irq <= mode_cond_irq ? (start_det | stop_det)
                : ((start_det & start_irq_en) | (stop_det & stop_irq_en));
        end
    end

    // ==========================================
    // client receiver
    logic rx_active;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic first_byte;
    logic ack_phase;
    logic hold_sel;
    logic full_at;
    logic hw_stretch;
    logic push_pending;
    logic fifo_in_ready;
    logic host_active;

    wire client_act = client_en & rx_active & ~host_active;
    wire eighth_fall = client_act & scl_fall & ~ack_phase
        & (bit_cnt == 4'(`BITS_PER_BYTE));
    wire ninth_fall = client_act & scl_fall & ack_phase;
    wire byte_hold = first_byte ? addr_hold_en : data_hold_en;
    wire rd_request = first_byte & shift[`RW_BIT_POS];
    wire ack_low = client_act & ack_phase
        & (hold_sel ? ~ack_value_sel : ~full_at);

    // bit counter and shifter, counter reset by any start
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_active <= 1'b0;
            bit_cnt <= '0;
            shift <= '0;
            first_byte <= 1'b0;
            ack_phase <= 1'b0;
        end else if (ce) begin
            if (start_det) begin
                rx_active <= 1'b1;
                bit_cnt <= '0;
                first_byte <= 1'b1;
                ack_phase <= 1'b0;
            end else if (stop_det) begin
                rx_active <= 1'b0;
                ack_phase <= 1'b0;
            end else if (client_act && scl_rise && !ack_phase
                         && bit_cnt < 4'(`BITS_PER_BYTE)) begin
                shift <= {shift[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (eighth_fall) begin
                ack_phase <= 1'b1;
            end else if (ninth_fall) begin
                ack_phase <= 1'b0;
                bit_cnt <= '0;
                first_byte <= 1'b0;
            end
        end
    end

    // acknowledge decision captured at the eighth falling edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_sel <= 1'b0;
            full_at <= 1'b0;
            ack_window_flag <= 1'b0;
            read_req <= 1'b0;
        end else if (ce) begin
            read_req <= eighth_fall & rd_request;
            if (eighth_fall) begin
                hold_sel <= byte_hold;
                full_at <= buffer_full_flag | rx_overflow_flag;
                ack_window_flag <= addr_hold_en | data_hold_en;
            end else if (ninth_fall || start_det) begin
                ack_window_flag <= 1'b0;
            end
        end
    end

    // stretch requests and fifo hand-off
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hw_stretch <= 1'b0;
            push_pending <= 1'b0;
        end else if (ce) begin
            if (eighth_fall && (byte_hold || rd_request)) hw_stretch <= 1'b1;
            else if (release_rise || start_det) hw_stretch <= 1'b0;
            if (eighth_fall) push_pending <= 1'b1;
            else if (fifo_in_ready) push_pending <= 1'b0;
        end
    end

    rx_fifo #(
        .WIDTH($bits(i2c_cond_pkg::rx_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(push_pending),
        .in_ready(fifo_in_ready),
        .in_data({first_byte, shift}),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // ==========================================
    // host sequencer
    i2c_cond_pkg::host_state_t hstate;
    logic [HW-1:0] div_cnt;
    logic [3:0] hbit;
    logic [7:0] hbyte;

    wire half_done = (div_cnt == HW'(HALF_CYC - 1));
    wire in_ack = (hbit == 4'(`ACK_SLOT));
    wire cur_bit = hbyte[3'(7 - hbit)];
    wire arb_miss = (hstate == i2c_cond_pkg::H_HIGH) & scl_s & ~in_ack
        & cur_bit & ~sda_s;
    assign host_active = (hstate != i2c_cond_pkg::H_IDLE)
        & (hstate != i2c_cond_pkg::H_LOST);
    assign host_busy = (hstate != i2c_cond_pkg::H_IDLE);

    // half period divider, high half waits for real scl high
    always_ff @(posedge clk) begin
        if (!rstn) begin
            div_cnt <= '0;
        end else if (ce) begin
            if (hstate == i2c_cond_pkg::H_IDLE || half_done) div_cnt <= '0;
            else if (hstate != i2c_cond_pkg::H_HIGH || scl_s) div_cnt <= div_cnt + HW'(1);
        end
    end

    // host state transitions
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hstate <= i2c_cond_pkg::H_IDLE;
            hbit <= '0;
            hbyte <= '0;
            ack_result_flag <= 1'b0;
            arb_lost <= 1'b0;
            bus_collision <= 1'b0;
        end else if (ce) begin
            arb_lost <= 1'b0;
            bus_collision <= 1'b0;
            unique case (hstate)
                i2c_cond_pkg::H_IDLE: begin
                    if (host_start_req && !bus_busy) begin
                        hbyte <= host_tx_data;
                        hstate <= i2c_cond_pkg::H_START;
                    end
                end
                i2c_cond_pkg::H_START: begin
                    if (div_cnt == '0 && !sda_s) begin
                        bus_collision <= 1'b1;
                        hstate <= i2c_cond_pkg::H_IDLE;
                    end else if (half_done) begin
                        hbit <= '0;
                        hstate <= i2c_cond_pkg::H_LOW;
                    end
                end
                i2c_cond_pkg::H_LOW: begin
                    if (half_done) hstate <= i2c_cond_pkg::H_HIGH;
                end
                i2c_cond_pkg::H_HIGH: begin
                    if (arb_miss) begin
                        arb_lost <= 1'b1;
                        hstate <= i2c_cond_pkg::H_LOST;
                    end else if (half_done && in_ack) begin
                        ack_result_flag <= sda_s;
                        hstate <= i2c_cond_pkg::H_STOP_LOW;
                    end else if (half_done) begin
                        hbit <= hbit + 4'h1;
                        hstate <= i2c_cond_pkg::H_LOW;
                    end
                end
                i2c_cond_pkg::H_STOP_LOW: begin
                    if (half_done) hstate <= i2c_cond_pkg::H_STOP_HIGH;
                end
                i2c_cond_pkg::H_STOP_HIGH: begin
                    if (half_done) hstate <= i2c_cond_pkg::H_IDLE;
                end
                i2c_cond_pkg::H_LOST: begin
                    if (!bus_busy) hstate <= i2c_cond_pkg::H_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // pin drive: open drain, only pull low
    logic [`HOLD_CNT_W-1:0] hold_cnt;
    logic scl_hold;

    wire host_scl_low = (hstate == i2c_cond_pkg::H_LOW)
        | (hstate == i2c_cond_pkg::H_STOP_LOW);
    wire host_sda_low = (hstate == i2c_cond_pkg::H_START)
        | (hstate == i2c_cond_pkg::H_STOP_LOW) | (hstate == i2c_cond_pkg::H_STOP_HIGH)
        | ((hstate == i2c_cond_pkg::H_LOW || hstate == i2c_cond_pkg::H_HIGH)
           & ~in_ack & ~cur_bit);
    // idle release skips the hold only with scl high and no ack pending
    wire cond_phase = (hstate == i2c_cond_pkg::H_START)
        | (hstate == i2c_cond_pkg::H_STOP_HIGH)
        | ((hstate == i2c_cond_pkg::H_IDLE || hstate == i2c_cond_pkg::H_LOST)
           & scl_s & ~ack_phase);
    wire data_slot = ~scl_s & ~scl_fall & (hold_cnt == '0);
    wire want_hold = rx_active & (~clock_release_ctl | hw_stretch | push_pending);
    wire [`HOLD_CNT_W-1:0] hold_load = sda_hold_long_sel
        ? `HOLD_CNT_W'(`HOLD_LONG_CYC) : `HOLD_CNT_W'(`HOLD_STD_CYC);

    // hold time counter restarts at every scl falling edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_cnt <= '0;
        end else if (ce) begin
            if (scl_fall) hold_cnt <= hold_load;
            else if (hold_cnt != '0) hold_cnt <= hold_cnt - `HOLD_CNT_W'(1);
        end
    end

    // sda changes only after hold, conditions and arbitration loss bypass it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sda_oe <= 1'b0;
        end else if (ce) begin
            if (data_slot || cond_phase || arb_miss) begin
                sda_oe <= (host_sda_low & ~arb_miss) | ack_low;
            end
        end
    end

    // scl held only once already seen low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_hold <= 1'b0;
            scl_oe <= 1'b0;
        end else if (ce) begin
            scl_hold <= want_hold & (scl_hold | ~scl_s);
            scl_oe <= host_scl_low | (want_hold & (scl_hold | ~scl_s));
        end
    end

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
endmodule

//--- verification/i2c_bus_engine_chk.sv
module i2c_bus_engine_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic sda_hold_long_sel,
    input wire logic start_irq_en,
    input wire logic stop_irq_en,
    input wire logic mode_cond_irq,
    input wire logic addr_hold_en,
    input wire logic data_hold_en,
    input wire logic host_busy,
    input wire logic arb_lost,
    input wire logic bus_collision,
    input wire logic ack_window_flag,
    input wire logic bus_busy,
    input wire i2c_cond_pkg::bus_ev_t bus_event,
    input wire logic cond_irq
);
    logic [7:0] low_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ========
    // cycles the scl line has stayed low
    always_ff @(posedge clk) begin
        if (!rstn || scl_in) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    sequence s_busy_set;
        ##[0:2] bus_busy;
    endsequence
    sequence s_busy_clr;
        ##[0:2] !bus_busy;
    endsequence
    a_hold_time_kept: assert property (
        !scl_in && $changed(sda_oe) |-> low_cnt >= (sda_hold_long_sel ? 8'h0F : 8'h05))
        else $error("sda moved too soon after scl fall");
    a_stretch_when_low: assert property (
        !host_busy && $rose(scl_oe) |-> $past(scl_in) == 1'b0)
        else $error("clock hold began while scl high");
    a_host_idle_start: assert property ($rose(host_busy) |-> !$past(bus_busy))
        else $error("host began on a busy bus");
    a_arb_release: assert property (
        arb_lost |-> ##[0:1] (!sda_oe && !scl_oe))
        else $error("lost host still drives");
    a_start_sets_busy: assert property (bus_event.start |-> s_busy_set)
        else $error("start left bus idle");
    a_collision_idle: assert property (bus_collision |-> ##[0:2] !host_busy)
        else $error("host kept going after collision");
    a_stop_clears_busy: assert property (bus_event.stop |-> s_busy_clr)
        else $error("stop left bus busy");
    a_irq_source: assert property (
        cond_irq |-> (|bus_event) && (mode_cond_irq || start_irq_en || stop_irq_en))
        else $error("interrupt without enabled event");
    a_irq_on_start: assert property (
        bus_event.start && (start_irq_en || mode_cond_irq) |-> cond_irq)
        else $error("enabled start gave no interrupt");
    a_window_hold_en: assert property (
        $rose(ack_window_flag) |-> $past(addr_hold_en) || $past(data_hold_en))
        else $error("ack window flag without hold enable");
endmodule

bind i2c_bus_engine i2c_bus_engine_chk chk (.clk, .rstn, .scl_in, .scl_oe, .sda_oe,
    .sda_hold_long_sel, .start_irq_en, .stop_irq_en, .mode_cond_irq, .addr_hold_en,
    .data_hold_en, .host_busy, .arb_lost, .bus_collision, .ack_window_flag, .bus_busy,
    .bus_event, .cond_irq);

//--- verification/i2c_peer.sv
module i2c_peer (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LO = 32;
    // ========
    // bus idles released
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait for a scl level
    task automatic w(input logic v);
        for (int i = 0; i < 4000 && scl !== v; i++) @(negedge clk);
    endtask
    // release scl and ride out stretching
    task automatic hi();
        scl_oe = 1'b0;
        w(1'b1);
        tk(4);
    endtask
    // start or repeated start, ends with scl low
    task automatic start();
        sda_oe = 1'b0;
        tk(LO);
        hi();
        sda_oe = 1'b1;
        tk(4);
        scl_oe = 1'b1;
        tk(8);
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        tk(LO);
        hi();
        sda_oe = 1'b0;
        tk(1);
    endtask
    // sda pulse with scl high, then one low period
    task automatic glitch();
        sda_oe = 1'b1;
        tk(8);
        sda_oe = 1'b0;
        tk(8);
        scl_oe = 1'b1;
        tk(LO);
    endtask
    // data set only while scl low
    task automatic bit1(input logic v, output logic r);
        sda_oe = !v;
        tk(LO);
        hi();
        r = sda;
        scl_oe = 1'b1;
        tk(8);
    endtask
    task automatic xfer(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bit1(d[i], r);
        bit1(1'b1, a);
    endtask
    // client for a host byte; k picks a bit to fight over
    task automatic serve(input logic nack, input int k, output logic [7:0] got);
        for (int i = 0; i < 4000 && sda; i++) @(negedge clk);
        w(1'b0);
        tk(6);
        for (int i = 0; i < 9; i++) begin
            if (i == 8) sda_oe = !nack;
            if (i == k) sda_oe = 1'b1;
            w(1'b1);
            if (i < 8) got = {got[6:0], sda};
            if (i == k) begin
                tk(20);
                sda_oe = 1'b0;
                return;
            end
            w(1'b0);
            tk(6);
            sda_oe = 1'b0;
        end
    endtask
endmodule

//--- verification/i2c_bus_condition_ack_arbitration_tb.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module i2c_bus_condition_ack_arbitration_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, sda_hold_long_sel = 0, clock_release_ctl = 1;
    logic start_irq_en = 0, stop_irq_en = 0, mode_cond_irq = 0, client_en = 1;
    logic addr_hold_en = 0, data_hold_en = 0, ack_value_sel = 0, rx_ready = 1;
    logic buffer_full_flag = 0, rx_overflow_flag = 0, host_start_req = 0, a;
    logic [7:0] host_tx_data = 0, d;
    logic scl_out, scl_oe, sda_out, sda_oe, host_busy, arb_lost, bus_collision;
    logic ack_result_flag, ack_window_flag, bus_busy, cond_irq, read_req, rx_valid;
    logic p_scl, p_sda;
    i2c_cond_pkg::bus_ev_t bus_event;
    i2c_cond_pkg::rx_word_t rx_data;
    i2c_cond_pkg::rx_word_t got_q[$], exp_q[$];
    int miscompares, cmp_count, cyc, n_st, n_rs, n_sp, n_irq, n_win, n_rd, n_arb, n_col;
    int s0, s1, s2, s3, s4;
    // ========
    // open-drain wires
    wire scl_in = !(scl_oe | p_scl);
    wire sda_in = !(sda_oe | p_sda);
    always #10 clk = !clk;
    i2c_bus_engine #(.HALF_CYC(32), .FIFO_DEPTH(8)) dut (.clk, .rstn, .ce(1'b1), .scl_in,
        .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .sda_hold_long_sel,
        .clock_release_ctl, .start_irq_en, .stop_irq_en, .mode_cond_irq, .client_en,
        .addr_hold_en, .data_hold_en, .ack_value_sel, .buffer_full_flag,
        .rx_overflow_flag, .host_start_req, .host_tx_data, .host_busy, .arb_lost,
        .bus_collision, .ack_result_flag, .ack_window_flag, .bus_busy, .bus_event,
        .cond_irq, .read_req, .rx_valid, .rx_ready, .rx_data);
    i2c_peer p (.clk, .scl(scl_in), .sda(sda_in), .scl_oe(p_scl), .sda_oe(p_sda));
    // event counters, fifo sink, timeout
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            miscompares++;
            wrap_up();
        end
        n_st += bus_event.start;
        n_rs += bus_event.restart;
        n_sp += bus_event.stop;
        n_irq += cond_irq;
        n_win += $rose(ack_window_flag);
        n_rd += read_req;
        n_arb += arb_lost;
        n_col += bus_collision;
        if (rx_valid && rx_ready) got_q.push_back(rx_data);
    end
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic ack_exp(logic h, logic s, logic f);
        return h ? s : f;
    endfunction
    function automatic int irq_exp(logic m, logic b, logic c);
        return int'(m | b) + int'(m | c);
    endfunction
    // clear hardware clock holds, twice at most
    task automatic unstretch();
        repeat (2) begin
            for (int i = 0; i < 500 && !scl_oe; i++) @(negedge clk);
            if (scl_oe) begin
                tk(10);
                clock_release_ctl = 1'b0;
                tk(2);
                clock_release_ctl = 1'b1;
                tk(4);
            end
        end
    endtask
    // one client byte between start and stop
    task automatic cli(input logic [7:0] v, input logic h, input logic s, input logic f);
        {mode_cond_irq, start_irq_en, stop_irq_en, sda_hold_long_sel} = 4'($urandom);
        {addr_hold_en, data_hold_en, ack_value_sel} = {h, h, s};
        {buffer_full_flag, rx_overflow_flag} = {f & v[1], f & !v[1]};
        {s0, s1, s2, s3, s4} = {n_st, n_sp, n_irq, n_win, n_rd};
        p.start();
        fork
            p.xfer(v, a);
            unstretch();
        join
        p.stop();
        tk(10);
        `CHK(a, ack_exp(h, s, f))
        `CHK(n_st - s0, 1)
        `CHK(n_sp - s1, 1)
        `CHK(n_irq - s2, irq_exp(mode_cond_irq, start_irq_en, stop_irq_en))
        `CHK(n_win - s3, int'(h))
        `CHK(n_rd - s4, int'(v[0]))
        `CHK(bus_busy, 1'b0)
    endtask
    // one host byte; k below 8 makes the peer fight, pre starts a rival first
    task automatic host(input logic [7:0] v, input logic nack, input int k, input logic pre);
        logic [7:0] g;
        s0 = n_arb;
        host_tx_data = v;
        if (pre) p.start();
        host_start_req = 1'b1;
        if (pre) begin
            tk(100);
            `CHK(host_busy, 1'b0)
            p.stop();
        end
        fork
            p.serve(nack, k, g);
            begin
                for (int i = 0; i < 300 && !host_busy; i++) @(negedge clk);
                host_start_req = 1'b0;
            end
        join
        for (int i = 0; i < 3000 && host_busy; i++) @(negedge clk);
        if (k > 7) begin
            `CHK(g, v)
            `CHK(ack_result_flag, nack)
        end
        `CHK(n_arb - s0, int'(k < 8))
        `CHK(host_busy, 1'b0)
    endtask
    initial begin
        void'($urandom(80));
        tk(8);
        rstn = 1'b1;
        tk(4);
        `CHK({sda_oe, scl_oe, bus_busy, host_busy, rx_valid}, 5'h00)
        cli(8'hA4, 1, 1, 0);
        cli(8'h5A, 1, 0, 0);
        cli(8'h36, 0, 0, 1);
        cli(8'h34, 0, 0, 1);
        cli(8'hA5, 0, 0, 0);
        $display("done: answers");
        rx_ready = 1'b0;
        got_q.delete();
        for (int i = 0; i < 9; i++) begin
            d = 8'($urandom) & 8'hFE;
            cli(d, 1'($urandom), 1'b0, 1'b0);
            exp_q.push_back({1'b1, d});
        end
        `CHK(got_q.size(), 0)
        rx_ready = 1'b1;
        tk(30);
        `CHK(got_q.size(), 9)
        foreach (exp_q[i]) `CHK(got_q[i], exp_q[i])
        $display("done: fifo");
        {s0, s1, s2} = {n_st, n_sp, n_rs};
        p.glitch();
        `CHK(n_st - s0, 1)
        `CHK(n_sp - s1, 0)
        p.stop();
        tk(10);
        `CHK(bus_busy, 1'b0)
        {addr_hold_en, data_hold_en} = 2'h0;
        got_q.delete();
        p.start();
        p.xfer(8'hC6, a);
        p.start();
        p.xfer(8'h3A, a);
        p.stop();
        tk(10);
        `CHK(n_rs - s2, 1)
        `CHK(got_q[1], 9'h13A)
        $display("done: conditions");
        client_en = 1'b0;
        host(8'($urandom), 1'b0, 9, 1'b0);
        host(8'($urandom), 1'b1, 9, 1'b0);
        host(8'($urandom), 1'b0, 9, 1'b1);
        host(8'hFF, 1'b0, 3, 1'b0);
        s0 = n_col;
        p.sda_oe = 1'b1;
        tk(1);
        host_start_req = 1'b1;
        tk(40);
        host_start_req = 1'b0;
        `CHK(n_col - s0, 1)
        p.glitch();
        p.stop();
        $display("done: host");
        wrap_up();
    end
endmodule
